// ### hw/strap_cfg.sv
// reset strap capture, clock ratio configuration and pad control
// assumes strap pins are board resistors, asynchronous to hclk, and
// a memory controller on hclk reporting reads in progress
//
// Overview of operation
// - sample ratio and configuration straps during reset
// - code sets memory and cpu multipliers
// - readback field shows only the cpu multiplier
// - eleven codes are reserved, board must avoid
// - bypass codes: reference clocks cpu, pll off
// - codes 11110, 11111 stop all internal clocking
// - data receivers off unless reading
// - 32-bit mode: low lane, checks 4-7 zero
// - strap pull-ups on only during reset
// - request and test port pull-ups always on
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
module strap_cfg
  import strap_cfg_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic [CODE_W-1:0] ratio_strap,
  input  wire logic              grant_four_strap,
  input  wire logic              flash_output_strap,
  input  wire logic              rom_select_strap,
  input  wire logic [2:0]        memory_addr_attr_strap,
  input  wire logic [2:0]        parity_addr_attr_strap,
  input  wire logic              quiesce_ack_strap,
  input  wire logic              machine_check_out_strap,
  input  wire logic              low_data_lane_strap,
  input  wire logic              read_active,
  output logic                   strap_pullup_en,
  output logic                   fixed_pullup_en,
  output logic [MULT_W-1:0]      mem_mult,
  output logic [MULT_W-1:0]      cpu_mult,
  output logic [CODE_W-1:0]      cpu_ratio_readback_field,
  output logic                   cpu_clk_from_ref,
  output logic                   periph_pll_en,
  output logic                   bus_one_to_one,
  output logic                   clocks_run,
  output logic                   bus32_mode,
  output logic                   high_data_lane_rx_en,
  output logic                   low_data_lane_rx_en,
  output logic [CHK_W-1:0]       memory_check_bits_rx_en,
  output logic                   low_data_lane_drive_zero,
  output logic [CHK_W-1:0]       memory_check_bits_drive_zero
);

  // ****************************************
  // strap synchronisers
  // ****************************************
  // no reset here on purpose: these flops keep sampling the pins
  // while the block is held in reset, so the capture at release
  // sees levels taken during reset
  logic [CODE_W+MISC_W-1:0] pin_s1;
  logic [CODE_W+MISC_W-1:0] pin_s2;
  logic [CODE_W+MISC_W-1:0] pin_raw;

  assign pin_raw = {ratio_strap, low_data_lane_strap,
                    grant_four_strap, flash_output_strap,
                    rom_select_strap, memory_addr_attr_strap,
                    parity_addr_attr_strap, quiesce_ack_strap,
                    machine_check_out_strap, 1'b0};

  always_ff @(posedge hclk)
  begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
  end

  // ****************************************
  // capture sequence
  // ****************************************
  cap_e              cap_r;
  logic [CODE_W-1:0] code_r;
  logic [MISC_W-1:0] misc_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap_r <= CAP_LATCH;
    else
      cap_r <= CAP_RUN;
  end

  // one capture on the first edge after release, then frozen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      code_r <= CODE_RST;
      misc_r <= MISC_RST;
    end
    else if (cap_r == CAP_LATCH)
    begin
      code_r <= pin_s2[CODE_W+MISC_W-1:MISC_W];
      misc_r <= pin_s2[MISC_W-1:0];
    end
  end

  // ****************************************
  // ratio decode
  // ****************************************
  ratio_if rif ();

  assign rif.code = code_r;

  ratio_decode u_dec (
    .rif (rif)
  );

  logic done;
  assign done = (cap_r == CAP_RUN);

  // ****************************************
  // clock configuration outputs
  // ****************************************
  // until the capture lands every clock stays off, so no domain
  // starts from the reset default code
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_mult                 <= '0;
      cpu_mult                 <= '0;
      cpu_ratio_readback_field <= '0;
      cpu_clk_from_ref         <= 1'b0;
      periph_pll_en            <= 1'b0;
      bus_one_to_one           <= 1'b0;
      clocks_run               <= 1'b0;
    end
    else
    begin
      mem_mult                 <= rif.mem_mult;
      cpu_mult                 <= rif.cpu_mult;
      cpu_ratio_readback_field <= rif.hid;
      cpu_clk_from_ref         <= done && rif.bypass;
      bus_one_to_one           <= done && rif.bypass;
      // reserved codes are treated as unsafe: the pll stays off
      periph_pll_en            <= done && !rif.bypass && !rif.clk_off
                                  && !rif.rsvd;
      clocks_run               <= done && !rif.clk_off;
    end
  end

  // ****************************************
  // pull-up control
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      strap_pullup_en <= 1'b1;
    else
      strap_pullup_en <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fixed_pullup_en <= 1'b1;
    else
      fixed_pullup_en <= 1'b1;
  end

  // ****************************************
  // control register
  // ****************************************
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic        bus32;

  // a low level on the low lane strap picks the 32-bit data bus
  assign bus32 = !misc_r[MISC_DL0];

  // ****************************************
  // memory data receivers and drivers
  // ****************************************
  // software may hold every receiver off, e.g. while the memory
  // controller is idle for long stretches; reads then return zero
  logic rx_ok;
  assign rx_ok = read_active && done && !ctrl_r[CTRL_RXOFF];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus32_mode                   <= 1'b0;
      high_data_lane_rx_en         <= 1'b0;
      low_data_lane_rx_en          <= 1'b0;
      memory_check_bits_rx_en      <= '0;
      low_data_lane_drive_zero     <= 1'b0;
      memory_check_bits_drive_zero <= '0;
    end
    else
    begin
      bus32_mode                   <= bus32;
      high_data_lane_rx_en         <= rx_ok;
      low_data_lane_rx_en          <= rx_ok && !bus32;
      memory_check_bits_rx_en      <= {{(CHK_W/2){rx_ok && !bus32}},
                                       {(CHK_W/2){rx_ok}}};
      low_data_lane_drive_zero     <= bus32;
      memory_check_bits_drive_zero <= {{(CHK_W/2){bus32}},
                                       {(CHK_W/2){1'b0}}};
    end
  end

  // ****************************************
  // ahb-lite address phase
  // ****************************************
  logic       acc;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;

  assign acc = hsel && hready && htrans[1];

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= acc && hwrite;
      if (acc)
        wr_addr_r <= haddr[7:0];
    end
  end

  // ****************************************
  // ahb-lite data phase write
  // ****************************************
  function automatic logic hit(input logic [31:0] a,
                               input logic [7:0]  ofs);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
  endfunction

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_pend_r && hit({24'h000000, wr_addr_r}, OFS_CTRL))
      ctrl_nxt = {31'h0000_0000, hwdata[CTRL_RXOFF]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= CTRL_RST;
    else
      ctrl_r <= ctrl_nxt;
  end

  // ****************************************
  // read data
  // ****************************************
  // read data is registered at the address phase edge, using the
  // next control value so a write just before a read is seen
  logic [31:0] rd_nxt;

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (hit(haddr, OFS_STATUS))
    begin
      rd_nxt[CODE_W-1:0] = code_r;
      rd_nxt[ST_BYPASS]  = rif.bypass;
      rd_nxt[ST_CLKOFF]  = rif.clk_off;
      rd_nxt[ST_RSVD]    = rif.rsvd;
      rd_nxt[ST_BUS32]   = bus32;
      rd_nxt[ST_DONE]    = done;
    end
    else if (hit(haddr, OFS_CPU_RATIO))
      rd_nxt[CODE_W-1:0] = rif.hid;
    else if (hit(haddr, OFS_MULT))
    begin
      rd_nxt[MULT_W-1:0] = rif.mem_mult;
      rd_nxt[MULT_CPU_LSB +: MULT_W] = rif.cpu_mult;
    end
    else if (hit(haddr, OFS_STRAPS))
      rd_nxt[MISC_W-1:0] = misc_r;
    else if (hit(haddr, OFS_CTRL))
      rd_nxt = ctrl_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (acc && !hwrite)
      hrdata <= rd_nxt;
  end

endmodule

// ### shared/strap_cfg_pkg.sv
// constants shared by the reset strap configuration block
// assumes a 32-bit ahb-lite slave with one aligned word per register
package strap_cfg_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CPU_RATIO = 8'h04;
  localparam logic [7:0] OFS_MULT = 8'h08;
  localparam logic [7:0] OFS_STRAPS = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int CODE_W = 5;
  localparam int MULT_W = 4;
  localparam int MISC_W = 13;
  localparam int CHK_W = 8;
  localparam int ST_BYPASS = 5;
  localparam int ST_CLKOFF = 6;
  localparam int ST_RSVD = 7;
  localparam int ST_BUS32 = 8;
  localparam int ST_DONE = 9;
  localparam int MULT_CPU_LSB = 8;
  localparam int CTRL_RXOFF = 0;
  localparam int MISC_DL0 = 12;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CODE_W-1:0] CODE_RST = 5'h1f;
  localparam logic [MISC_W-1:0] MISC_RST = 13'h1fff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [MULT_W-1:0] MULT_1TO1 = 4'h2;

  typedef enum logic [1:0] {CAP_LATCH, CAP_RUN} cap_e;

endpackage

// ### shared/ratio_if.sv
// bundle between the strap code and its ratio decoder
// assumes the decoder is purely combinational
interface ratio_if;
  import strap_cfg_pkg::*;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] hid;
  logic [MULT_W-1:0] mem_mult;
  logic [MULT_W-1:0] cpu_mult;
  logic              bypass;
  logic              clk_off;
  logic              rsvd;
  modport dec (input code, output hid, mem_mult, cpu_mult, bypass,
               clk_off, rsvd);
  modport use_side (output code, input hid, mem_mult, cpu_mult,
                    bypass, clk_off, rsvd);
endinterface

// ### hw/ratio_decode.sv
// decodes the 5-bit clock ratio strap code into multipliers and modes
// assumes code[4] is strap pin 0; multipliers are given in halves
module ratio_decode
  import strap_cfg_pkg::*;
(
  ratio_if.dec rif
);

  logic [CODE_W+2*MULT_W-1:0] v;

  // ****************************************
  // code table: {cpu readback, mem x2, cpu x2}
  // ****************************************
  always_comb
  begin
    v = '0;
    rif.rsvd = 1'b0;
    unique case (rif.code)
      5'h00: v = {5'h06, 4'h6, 4'h5};
      5'h01: v = {5'h18, 4'h6, 4'h6};
      5'h02: v = {5'h05, 4'h2, 4'h4};
      5'h03: v = {5'h05, MULT_1TO1, 4'h4};
      5'h04: v = {5'h05, 4'h4, 4'h4};
      5'h05: v = {5'h06, MULT_1TO1, 4'h5};
      5'h07: v = {5'h18, MULT_1TO1, 4'h6};
      5'h08: v = {5'h18, 4'h2, 4'h6};
      5'h0a: v = {5'h07, 4'h4, 4'h9};
      5'h0c: v = {5'h06, 4'h4, 4'h5};
      5'h0e: v = {5'h18, 4'h4, 4'h6};
      5'h10: v = {5'h04, 4'h6, 4'h4};
      5'h12: v = {5'h04, 4'h3, 4'h4};
      5'h14: v = {5'h1e, 4'h4, 4'h7};
      5'h16: v = {5'h1a, 4'h4, 4'h8};
      5'h18: v = {5'h18, 4'h5, 4'h6};
      5'h1a: v = {5'h1a, 4'h2, 4'h8};
      5'h1c: v = {5'h18, 4'h3, 4'h6};
      5'h1d: v = {5'h06, 4'h3, 4'h5};
      5'h1e: v = {5'h0f, 4'h0, 4'h0};
      5'h1f: v = {5'h1f, 4'h0, 4'h0};
      default: rif.rsvd = 1'b1;
    endcase
  end

  assign rif.hid = v[CODE_W+2*MULT_W-1:2*MULT_W];
  assign rif.mem_mult = v[2*MULT_W-1:MULT_W];
  assign rif.cpu_mult = v[MULT_W-1:0];
  assign rif.bypass = (rif.code == 5'h03) || (rif.code == 5'h05)
                   || (rif.code == 5'h07);
  assign rif.clk_off = (rif.code == 5'h1e) || (rif.code == 5'h1f);

endmodule

// ### verif/strap_board.sv
// board straps: pins are pulled down or left open
// assumes the device pull-up enable is fed back from the design
module strap_board
  import strap_cfg_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              pullup_en,
  input  wire logic [CODE_W-1:0] code_pd,
  input  wire logic [MISC_W-1:0] misc_pd,
  output logic      [CODE_W-1:0] code_pin,
  output logic      [MISC_W-1:0] misc_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ******
  // pins
  // ******
  logic flt = 1'b0;
  // an open pin floats once pull-ups drop: toggle so no stale level
  always @(posedge hclk)
    flt <= ~flt;
  // only the codes the bench commands are strapped
  assign code_pin = ~code_pd & (pullup_en ? '1 : {CODE_W{flt}});
  assign misc_pin = ~misc_pd & (pullup_en ? '1 : {MISC_W{flt}});
endmodule

// ### verif/strap_cfg_chk.sv
// port assertions of the strap configuration block
// assumes reset is held at least three edges
module strap_cfg_chk
  import strap_cfg_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              read_active,
  input wire logic              strap_pullup_en,
  input wire logic              fixed_pullup_en,
  input wire logic [MULT_W-1:0] mem_mult,
  input wire logic [MULT_W-1:0] cpu_mult,
  input wire logic [CODE_W-1:0] cpu_ratio_readback_field,
  input wire logic              cpu_clk_from_ref,
  input wire logic              periph_pll_en,
  input wire logic              bus_one_to_one,
  input wire logic              clocks_run,
  input wire logic              bus32_mode,
  input wire logic              high_data_lane_rx_en,
  input wire logic              low_data_lane_rx_en,
  input wire logic [CHK_W-1:0]  memory_check_bits_rx_en,
  input wire logic              low_data_lane_drive_zero,
  input wire logic [CHK_W-1:0]  memory_check_bits_drive_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  // ******
  // helpers
  // ******
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic [1:0] up_cnt;
  // decoded outputs settle two edges after release
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      up_cnt <= 2'd0;
    else if (up_cnt != 2'd3)
      up_cnt <= up_cnt + 2'd1;
  sequence s_ratio_rd;
    hsel && hready && htrans[1] && !hwrite && haddr == 32'h4;
  endsequence
  // ******
  // assertions
  // ******
  a_pullup_off: assert property
    ($past(hresetn) |-> !strap_pullup_en) else $error("pull-up on");
  a_pullup_fixed: assert property
    (fixed_pullup_en) else $error("fixed pull-up off");
  a_straps_held: assert property
    (up_cnt == 2'd3 |-> $stable(mem_mult) && $stable(cpu_mult)
     && $stable(cpu_ratio_readback_field)) else $error("ratio moved");
  a_rx_idle: assert property
    (up_cnt != 2'd0 && !read_active |=> !high_data_lane_rx_en
     && !low_data_lane_rx_en && memory_check_bits_rx_en == 8'h00)
    else $error("receiver on while idle");
  a_bus32_lane: assert property
    (up_cnt == 2'd3 && bus32_mode |-> !low_data_lane_rx_en
     && memory_check_bits_rx_en[7:4] == 4'h0 && low_data_lane_drive_zero
     && memory_check_bits_drive_zero == 8'hf0) else $error("lane live");
  a_bypass_mode: assert property
    (up_cnt[1] && cpu_clk_from_ref |-> bus_one_to_one && !periph_pll_en
     && mem_mult == MULT_1TO1) else $error("bypass wrong");
  a_clock_off: assert property
    (up_cnt[1] && !clocks_run |-> mem_mult == 4'h0 && cpu_mult == 4'h0
     && !periph_pll_en && !cpu_clk_from_ref) else $error("clock-off wrong");
  a_readback_reg: assert property
    (s_ratio_rd |=> hrdata == {27'h0, cpu_ratio_readback_field})
    else $error("readback register wrong");
endmodule

bind strap_cfg strap_cfg_chk chk (.*);

// ### verif/test_strap_cfg.sv
// self-checking bench of the strap configuration block
// assumes the board model is the only driver of strap pins
module test_strap_cfg
  import strap_cfg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic read_active = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [4:0] code_pd = 5'h1f, code_pin, cpu_ratio_readback_field;
  logic [12:0] misc_pd = 13'h0, misc_pin;
  logic [3:0] mem_mult, cpu_mult;
  logic [7:0] memory_check_bits_rx_en, memory_check_bits_drive_zero;
  logic strap_pullup_en, fixed_pullup_en, cpu_clk_from_ref;
  logic periph_pll_en, bus_one_to_one, clocks_run, bus32_mode;
  logic high_data_lane_rx_en, low_data_lane_rx_en, low_data_lane_drive_zero;
  int miscompares = 0, samples_checked = 0;
  logic [23:0] tbl [23] = '{24'h000665, 24'h011866, 24'h020524,
    24'h030524, 24'h040544, 24'h050625, 24'h071826, 24'h081826,
    24'h0a0749, 24'h0c0645, 24'h0e1846, 24'h100464, 24'h120434,
    24'h141e47, 24'h161a48, 24'h181856, 24'h1a1a28, 24'h1c1836,
    24'h1d0635, 24'h1e0f00, 24'h1f1f00, 24'h860000, 24'h9b0000};
  always #12.5 hclk = ~hclk;
  strap_board board (.hclk, .pullup_en(strap_pullup_en), .code_pd,
    .misc_pd, .code_pin, .misc_pin);
  strap_cfg DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .ratio_strap(code_pin), .grant_four_strap(misc_pin[11]),
    .flash_output_strap(misc_pin[10]), .rom_select_strap(misc_pin[9]),
    .memory_addr_attr_strap(misc_pin[8:6]),
    .parity_addr_attr_strap(misc_pin[5:3]),
    .quiesce_ack_strap(misc_pin[2]), .machine_check_out_strap(misc_pin[1]),
    .low_data_lane_strap(misc_pin[12]), .read_active, .strap_pullup_en,
    .fixed_pullup_en, .mem_mult, .cpu_mult, .cpu_ratio_readback_field,
    .cpu_clk_from_ref, .periph_pll_en, .bus_one_to_one, .clocks_run,
    .bus32_mode, .high_data_lane_rx_en, .low_data_lane_rx_en,
    .memory_check_bits_rx_en, .low_data_lane_drive_zero,
    .memory_check_bits_drive_zero);
  // ******
  // tasks
  // ******
  task automatic wrap_up();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wait_ready();
    int n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic do_reset(input logic [4:0] c, input logic [12:0] m);
    code_pd <= c;
    misc_pd <= m;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    chk({29'h0, hreadyout, strap_pullup_en, fixed_pullup_en},
        32'h3);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  function automatic logic [31:0] rx();
    return {22'h0, high_data_lane_rx_en, low_data_lane_rx_en,
            memory_check_bits_rx_en};
  endfunction
  // ******
  // tests
  // ******
  initial
  begin
    logic [31:0] q;
    logic [23:0] t;
    logic byp, off;
    for (int i = 0; i < 23; i++)
    begin
      t = tbl[i];
      byp = t[20:16] inside {5'h03, 5'h05, 5'h07};
      off = t[20:16] >= 5'h1e;
      do_reset(~t[20:16], 13'h0);
      chk({24'h0, mem_mult, cpu_mult}, {24'h0, t[7:0]});
      chk({28'h0, cpu_clk_from_ref, bus_one_to_one, periph_pll_en,
           clocks_run}, {28'h0, byp, byp, !(byp | off | t[23]),
           !off});
      ahb(32'h4, 1'b0, 32'h0, q);
      if (!t[23])
      begin
        chk(q, {27'h0, t[12:8]});
        chk({27'h0, cpu_ratio_readback_field}, {27'h0, t[12:8]});
      end
      ahb(32'h0, 1'b0, 32'h0, q);
      chk(q, {22'h0, 2'b10, t[23], off, byp, t[20:16]});
    end
    $display("test ratio codes done");
    read_active <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(rx(), 32'h3ff);
    chk({22'h0, bus32_mode, low_data_lane_drive_zero,
         memory_check_bits_drive_zero}, 32'h0);
    do_reset(5'h1f, 13'h14a5);
    chk(rx(), 32'h20f);
    chk({22'h0, bus32_mode, low_data_lane_drive_zero,
         memory_check_bits_drive_zero}, 32'h3f0);
    repeat (20) @(posedge hclk);
    ahb(32'hc, 1'b0, 32'h0, q);
    chk(q & 32'h1ffe, 32'h0b5a);
    read_active <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(rx(), 32'h0);
    $display("test data lanes done");
    read_active <= 1'b1;
    ahb(32'h10, 1'b1, 32'h1, q);
    ahb(32'h10, 1'b0, 32'h0, q);
    chk(q, 32'h1);
    chk(rx(), 32'h0);
    ahb(32'h10, 1'b1, 32'h0, q);
    ahb(32'h100, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(32'h0, 1'b1, 32'hffffffff, q);
    ahb(32'h0, 1'b0, 32'h0, q);
    chk(q, 32'h300);
    chk(rx(), 32'h20f);
    $display("test registers done");
    wrap_up();
  end
endmodule
